// ==== src/sbte_core.sv ====
// Notes on behaviour
// - System-bus mode 9->8 halts only when ch9 matched before ch8; both enabled.
// - Reverse system-bus mode 8->9 halts only when ch8 matched before ch9.
// - Extended mode allows any channel ordering for CPU and system-bus groups.
// - Extended channel with a predecessor counts only after that predecessor matched.
// - Predecessor set to CPU match flag counts only while the flag is set.
// - A channel acting as predecessor never breaks itself; it only advances.
// - Each channel's match may set or clear the CPU match flag.
// - Any break returns the CPU match flag to its initial value.
// - Branch record holds source, destination, branch kind and bus master type.
// - Channel 12 selects captured branch kinds when its trace action is on.
// - Accesses inside a configured address window are captured into trace.
// - Window trace qualified by read/write type, bus cycle kind, optional ASID.
// - Window trace lives on operand-access channels 5 and 6 as range compares.
// - ASID marked don't care matches accesses of every address space.
// - Software trace instruction records its PC and one general register.
// - Zero-displacement branch_if_false / branch_if_true produce no branch record.
// - The reset jump to the reset vector is never branch-traced.
// - Completion exception branch records the address after the faulting instruction.
// - Fixed CPU chains halt only on strictly descending channel order.
//
// Design decisions made here: register access over Wishbone and the address map.
module sbte_core
    import sbte_pkg::*;
(
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Wishbone slave.
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    // Channel conditions from the comparators, bit n is channel n.
    input  wire logic [12:0]  ch_match_i,
    // Pipeline observation.
    input  wire sbte_branch_t branch_i,
    input  wire sbte_access_t access_i,
    input  wire logic         soft_trace_i,
    input  wire logic [31:0]  soft_pc_i,
    input  wire logic [31:0]  soft_reg_i,
    // Break and trace outputs.
    output logic              break_o,
    output logic              cpu_flag_o,
    output sbte_record_t      record_o
);

    typedef struct packed {
        logic [31:0]    ack_data;
        logic           ack;
        sbte_cpu_mode_t cpu_mode;
        sbte_sys_mode_t sys_mode;
        logic [12:0]    ch_en;
        logic [12:0]    seen;
        logic           cpu_flag;
        logic           brk;
        logic [31:0]    win5_lo;
        logic [31:0]    win5_hi;
        logic [31:0]    win6_lo;
        logic [31:0]    win6_hi;
        logic [16:0]    win_qual;
        logic [6:0]     br_qual;
        logic [12:0][5:0] pred;
        sbte_record_t   rec;
    } sbte_state_t;

    sbte_state_t s_reg;
    sbte_state_t s_next;

    // Chain membership: a channel in chain position k must see position k-1 latched.
    function automatic logic [12:0] chain_of(input sbte_cpu_mode_t m);
        unique case (m)
            SBTE_CPU_2_1:   chain_of = 13'h0006;
            SBTE_CPU_4_3:   chain_of = 13'h0018;
            SBTE_CPU_6_5:   chain_of = 13'h0060;
            SBTE_CPU_11_10: chain_of = 13'h0c00;
            SBTE_CPU_3_1:   chain_of = 13'h000e;
            SBTE_CPU_4_1:   chain_of = 13'h001e;
            SBTE_CPU_5_1:   chain_of = 13'h003e;
            SBTE_CPU_6_1:   chain_of = 13'h007e;
            SBTE_CPU_10_1:  chain_of = 13'h047e;
            SBTE_CPU_11_1:  chain_of = 13'h0c7e;
            default:        chain_of = 13'h0000;
        endcase
    endfunction

    // Next higher member of the chain, which must have matched first.
    function automatic logic [3:0] up_of(input logic [12:0] chain, input int n);
        up_of = 4'h0;
        for (int k = 12; k > n; k--) begin
            if (chain[k]) begin
                up_of = 4'(k);
            end
        end
    endfunction

    function automatic logic in_win(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction

    logic [12:0] chain;
    logic [12:0] counts;
    logic [12:0] is_pred;
    logic        fire;
    logic        flag_new;
    logic        acc_ok;
    logic        br_ok;
    logic        reconf;

    always_comb begin
        s_next  = s_reg;
        chain   = chain_of(s_reg.cpu_mode);
        counts  = '0;
        is_pred = '0;
        fire    = 1'b0;
        reconf  = 1'b0;
        flag_new = s_reg.cpu_flag;

        // Bus slave: one wait state, ack drops the cycle after it is given.
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
        s_next.ack_data = RST_ZERO;
        if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
            if (wb_we_i && wb_sel_i[0]) begin
                reconf = 1'b1;
                unique case (wb_adr_i)
                    ADDR_SEQ_MODE: begin
                        s_next.cpu_mode = sbte_cpu_mode_t'(wb_dat_i[SEQ_MODE_LSB +: 4]);
                        s_next.sys_mode = sbte_sys_mode_t'(wb_dat_i[SEQ_SYS_LSB +: 2]);
                    end
                    ADDR_CH_ENABLE: s_next.ch_en    = wb_dat_i[12:0];
                    ADDR_WIN5_LO:   s_next.win5_lo  = wb_dat_i;
                    ADDR_WIN5_HI:   s_next.win5_hi  = wb_dat_i;
                    ADDR_WIN6_LO:   s_next.win6_lo  = wb_dat_i;
                    ADDR_WIN6_HI:   s_next.win6_hi  = wb_dat_i;
                    ADDR_WIN_QUAL:  s_next.win_qual = wb_dat_i[16:0];
                    ADDR_BR_QUAL:   s_next.br_qual  = wb_dat_i[6:0];
                    default: begin
                        if (wb_adr_i >= ADDR_PRED_BASE && wb_adr_i[1:0] == 2'b00
                            && wb_adr_i[5:2] <= 4'hc) begin
                            s_next.pred[wb_adr_i[5:2]] = wb_dat_i[5:0];
                        end else begin
                            reconf = 1'b0;
                        end
                    end
                endcase
            end else if (!wb_we_i) begin
                unique case (wb_adr_i)
                    ADDR_SEQ_MODE:  s_next.ack_data = {26'h0, s_reg.sys_mode, s_reg.cpu_mode};
                    ADDR_CH_ENABLE: s_next.ack_data = {19'h0, s_reg.ch_en};
                    ADDR_STATUS:    s_next.ack_data = {17'h0, s_reg.cpu_flag, s_reg.brk,
                                                       s_reg.seen};
                    ADDR_WIN5_LO:   s_next.ack_data = s_reg.win5_lo;
                    ADDR_WIN5_HI:   s_next.ack_data = s_reg.win5_hi;
                    ADDR_WIN6_LO:   s_next.ack_data = s_reg.win6_lo;
                    ADDR_WIN6_HI:   s_next.ack_data = s_reg.win6_hi;
                    ADDR_WIN_QUAL:  s_next.ack_data = {15'h0, s_reg.win_qual};
                    ADDR_BR_QUAL:   s_next.ack_data = {25'h0, s_reg.br_qual};
                    default: begin
                        if (wb_adr_i >= ADDR_PRED_BASE && wb_adr_i[5:2] <= 4'hc) begin
                            s_next.ack_data = {26'h0, s_reg.pred[wb_adr_i[5:2]]};
                        end
                    end
                endcase
            end
        end

        // Sequencing. Matches count against latches from earlier cycles only.
        for (int n = 1; n < NCH; n++) begin
            logic [3:0] p;
            logic       ext;
            p   = PRED_NONE;
            ext = (n == 8 || n == 9) ? (s_reg.sys_mode == SBTE_SYS_EXT)
                                     : (s_reg.cpu_mode == SBTE_CPU_EXT);
            if (ext) begin
                p = s_reg.pred[n][PRED_SEL_LSB +: 4];
            end else if (n == 8 && s_reg.sys_mode == SBTE_SYS_9_8) begin
                p = 4'h9;
            end else if (n == 9 && s_reg.sys_mode == SBTE_SYS_8_9) begin
                p = 4'h8;
            end else if (n != 8 && n != 9 && chain[n]) begin
                p = up_of(chain, n);
            end
            if (p == PRED_FLAG) begin
                counts[n] = ch_match_i[n] && s_reg.cpu_flag;
            end else if (p != PRED_NONE && p <= 4'hc) begin
                counts[n] = ch_match_i[n] && s_reg.seen[p] && s_reg.ch_en[p];
                is_pred[p] = 1'b1;
            end else begin
                counts[n] = ch_match_i[n];
            end
            counts[n] = counts[n] && s_reg.ch_en[n];
        end

        for (int n = 1; n < NCH; n++) begin
            if (counts[n]) begin
                s_next.seen[n] = 1'b1;
                unique case (s_reg.pred[n][FLAG_ACT_LSB +: 2])
                    FLAG_SET:   flag_new = 1'b1;
                    FLAG_CLEAR: flag_new = 1'b0;
                    default:    ;
                endcase
                // Any non-predecessor channel may halt while either sequence mode is on; a predecessor just advances.
                if (!is_pred[n] && (s_reg.cpu_mode != SBTE_CPU_OFF
                                    || s_reg.sys_mode != SBTE_SYS_OFF)) begin
                    fire = 1'b1;
                end
            end
        end
        s_next.cpu_flag = flag_new;

        s_next.brk = fire;
        if (fire || reconf) begin
            s_next.seen     = '0;
        end
        if (fire) begin
            s_next.cpu_flag = RST_CPU_FLAG;
        end

        // Trace capture; software trace wins, then branch, then window access.
        acc_ok = access_i.valid
            && (access_i.write ? s_reg.win_qual[QUAL_RW_LSB + 1]
                               : s_reg.win_qual[QUAL_RW_LSB])
            && (access_i.cycle == s_reg.win_qual[QUAL_CYC_LSB +: 2])
            && (s_reg.win_qual[QUAL_ASID_DC]
                || access_i.asid == s_reg.win_qual[QUAL_ASID_LSB +: 8])
            && s_reg.win_qual[QUAL_TR_EN]
            && ((s_reg.ch_en[5] && in_win(access_i.addr, s_reg.win5_lo, s_reg.win5_hi))
                || (s_reg.ch_en[6] && in_win(access_i.addr, s_reg.win6_lo,
                                             s_reg.win6_hi)));
        br_ok = branch_i.valid && s_reg.ch_en[12]
            && s_reg.br_qual[6] && s_reg.br_qual[branch_i.kind]
            && !(branch_i.bf_bt && branch_i.zero_disp)
            && !(branch_i.kind == SBTE_BR_RESET && branch_i.dst == RESET_VECTOR);

        s_next.rec = '0;
        if (soft_trace_i) begin
            s_next.rec = '{1'b1, REC_SOFT, soft_pc_i, soft_reg_i, 3'h0, 2'h0};
        end else if (br_ok) begin
            s_next.rec = '{1'b1, REC_BRANCH,
                           branch_i.completion_exc ? branch_i.next_pc
                                                   : branch_i.src,
                           branch_i.dst, branch_i.kind, branch_i.master};
        end else if (acc_ok) begin
            s_next.rec = '{1'b1, REC_WINDOW, access_i.addr, access_i.data,
                           {access_i.write, access_i.cycle}, 2'h0};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg          <= '0;
            s_reg.cpu_flag <= RST_CPU_FLAG;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_dat_o   = s_reg.ack_data;
    assign wb_ack_o   = s_reg.ack;
    assign break_o    = s_reg.brk;
    assign cpu_flag_o = s_reg.cpu_flag;
    assign record_o   = s_reg.rec;

endmodule

// ==== src/sbte_pkg.sv ====
package sbte_pkg;

    // Channel numbering follows the event channels 1..12; index 0 is unused.
    localparam int NCH = 13;

    // Wishbone register byte offsets.
    localparam logic [7:0] ADDR_SEQ_MODE   = 8'h00;
    localparam logic [7:0] ADDR_CH_ENABLE  = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h08;
    localparam logic [7:0] ADDR_WIN5_LO    = 8'h0c;
    localparam logic [7:0] ADDR_WIN5_HI    = 8'h10;
    localparam logic [7:0] ADDR_WIN6_LO    = 8'h14;
    localparam logic [7:0] ADDR_WIN6_HI    = 8'h18;
    localparam logic [7:0] ADDR_WIN_QUAL   = 8'h1c;
    localparam logic [7:0] ADDR_BR_QUAL    = 8'h20;
    localparam logic [7:0] ADDR_PRED_BASE  = 8'h40;

    // Field positions.
    localparam int SEQ_MODE_LSB    = 0;
    localparam int SEQ_SYS_LSB     = 4;
    localparam int PRED_SEL_LSB    = 0;
    localparam int FLAG_ACT_LSB    = 4;
    localparam int QUAL_RW_LSB     = 0;
    localparam int QUAL_CYC_LSB    = 2;
    localparam int QUAL_ASID_DC    = 4;
    localparam int QUAL_ASID_LSB   = 8;
    localparam int QUAL_TR_EN      = 16;

    // Reset values.
    localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
    localparam logic        RST_CPU_FLAG = 1'b0;

    // Predecessor selection codes (0 none, 1..12 channel, 15 CPU match flag).
    localparam logic [3:0] PRED_NONE = 4'h0;
    localparam logic [3:0] PRED_FLAG = 4'hf;

    // Flag action codes.
    localparam logic [1:0] FLAG_KEEP  = 2'h0;
    localparam logic [1:0] FLAG_SET   = 2'h1;
    localparam logic [1:0] FLAG_CLEAR = 2'h2;

    localparam logic [31:0] RESET_VECTOR = 32'ha000_0000;

    typedef enum logic [3:0] {
        SBTE_CPU_OFF  = 4'h0,
        SBTE_CPU_2_1  = 4'h1,
        SBTE_CPU_4_3  = 4'h3,
        SBTE_CPU_6_5  = 4'h2,
        SBTE_CPU_11_10 = 4'h6,
        SBTE_CPU_3_1  = 4'h7,
        SBTE_CPU_4_1  = 4'h5,
        SBTE_CPU_5_1  = 4'h4,
        SBTE_CPU_6_1  = 4'hc,
        SBTE_CPU_10_1 = 4'hd,
        SBTE_CPU_11_1 = 4'hf,
        SBTE_CPU_EXT  = 4'he
    } sbte_cpu_mode_t;

    typedef enum logic [1:0] {
        SBTE_SYS_OFF = 2'h0,
        SBTE_SYS_9_8 = 2'h1,
        SBTE_SYS_8_9 = 2'h3,
        SBTE_SYS_EXT = 2'h2
    } sbte_sys_mode_t;

    typedef enum logic [2:0] {
        SBTE_BR_PLAIN = 3'h0,
        SBTE_BR_COND  = 3'h1,
        SBTE_BR_SUB   = 3'h2,
        SBTE_BR_EXC   = 3'h3,
        SBTE_BR_INT   = 3'h4,
        SBTE_BR_RESET = 3'h5
    } sbte_br_kind_t;

    // Observed branch from the pipeline.
    typedef struct packed {
        logic          valid;
        logic [31:0]   src;
        logic [31:0]   dst;
        sbte_br_kind_t kind;
        logic [1:0]    master;
        logic          bf_bt;
        logic          zero_disp;
        logic          completion_exc;
        logic [31:0]   next_pc;
    } sbte_branch_t;

    // Observed operand access.
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic [1:0]  cycle;
        logic [7:0]  asid;
        logic [31:0] data;
    } sbte_access_t;

    // Trace record handed to the collector.
    typedef struct packed {
        logic        valid;
        logic [1:0]  rtype;
        logic [31:0] word_a;
        logic [31:0] word_b;
        logic [2:0]  kind;
        logic [1:0]  master;
    } sbte_record_t;

    localparam logic [1:0] REC_BRANCH = 2'h0;
    localparam logic [1:0] REC_WINDOW = 2'h1;
    localparam logic [1:0] REC_SOFT   = 2'h2;

endpackage

// ==== test/sbte_chk_sva.sv ====
module sbte_chk
    import sbte_pkg::*;
(
    // Clock and reset.
    input wire logic         clk_i,
    input wire logic         rst_i,
    // Wishbone.
    input wire logic         wb_cyc_i,
    input wire logic         wb_stb_i,
    input wire logic         wb_ack_o,
    // Events and trace.
    input wire logic [12:0]  ch_match_i,
    input wire sbte_branch_t branch_i,
    input wire sbte_access_t access_i,
    input wire logic         soft_trace_i,
    input wire logic [31:0]  soft_pc_i,
    input wire logic [31:0]  soft_reg_i,
    input wire logic         break_o,
    input wire logic         cpu_flag_o,
    input wire sbte_record_t record_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_zero_br;
        branch_i.valid && branch_i.bf_bt && branch_i.zero_disp && !soft_trace_i
            && !access_i.valid;
    endsequence
    sequence s_reset_br;
        branch_i.valid && branch_i.kind == SBTE_BR_RESET && branch_i.dst == RESET_VECTOR
            && !soft_trace_i && !access_i.valid;
    endsequence

    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_break_cause: assert property (break_o |-> $past(ch_match_i) != 13'h0)
        else $error("break without match");
    a_break_flag: assert property (break_o |-> cpu_flag_o == RST_CPU_FLAG)
        else $error("flag kept over break");
    a_soft_rec: assert property (soft_trace_i |=> record_o.valid
        && record_o.rtype == REC_SOFT && record_o.word_a == $past(soft_pc_i)
        && record_o.word_b == $past(soft_reg_i)) else $error("soft record wrong");
    a_zero_skip: assert property (s_zero_br |=> !record_o.valid)
        else $error("zero displacement traced");
    a_reset_skip: assert property (s_reset_br |=> !record_o.valid)
        else $error("reset jump traced");
    a_idle_none: assert property (!branch_i.valid && !access_i.valid
        && !soft_trace_i |=> !record_o.valid) else $error("record without event");
    a_br_fields: assert property (record_o.valid && record_o.rtype == REC_BRANCH
        && !$past(branch_i.completion_exc) |-> record_o.word_a == $past(branch_i.src)
        && record_o.word_b == $past(branch_i.dst) && record_o.kind == $past(branch_i.kind)
        && record_o.master == $past(branch_i.master)) else $error("branch record wrong");
endmodule

bind sbte_core sbte_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ch_match_i(ch_match_i), .branch_i(branch_i),
    .access_i(access_i), .soft_trace_i(soft_trace_i), .soft_pc_i(soft_pc_i),
    .soft_reg_i(soft_reg_i), .break_o(break_o), .cpu_flag_o(cpu_flag_o),
    .record_o(record_o));

// ==== test/sbte_emu.sv ====
module sbte_emu
    import sbte_pkg::*;
(
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Records from the event logic.
    input  wire sbte_record_t record_i,
    // Records collected so far.
    output logic      [31:0]  rec_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The model takes records from the internal path only, since it is never wired
    // to the external trace port pins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rec_cnt_o <= '0;
        end else if (record_i.valid === 1'b1) begin
            rec_cnt_o <= rec_cnt_o + 32'h1;
        end
    end
endmodule

// ==== test/sequential_break_trace_events_tb.sv ====
module sequential_break_trace_events_tb
    import sbte_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         clk_i        = 1'b0;
    logic         rst_i        = 1'b1;
    logic         wb_cyc_i     = 1'b0;
    logic         wb_stb_i     = 1'b0;
    logic         wb_we_i      = 1'b0;
    logic [7:0]   wb_adr_i     = 8'h00;
    logic [3:0]   wb_sel_i     = 4'h0;
    logic [31:0]  wb_dat_i     = 32'h0;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic [12:0]  ch_match_i   = 13'h0;
    sbte_branch_t branch_i     = '0;
    sbte_access_t access_i     = '0;
    logic         soft_trace_i = 1'b0;
    logic [31:0]  soft_pc_i    = 32'h0;
    logic [31:0]  soft_reg_i   = 32'h0;
    logic         break_o;
    logic         cpu_flag_o;
    sbte_record_t record_o;
    logic [31:0]  rec_cnt;
    int           bad_count    = 0;
    int           checked      = 0;
    logic [31:0]  exp_rec      = 32'h0;

    always #5 clk_i = ~clk_i;

    sbte_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ch_match_i(ch_match_i),
        .branch_i(branch_i), .access_i(access_i), .soft_trace_i(soft_trace_i),
        .soft_pc_i(soft_pc_i), .soft_reg_i(soft_reg_i), .break_o(break_o),
        .cpu_flag_o(cpu_flag_o), .record_o(record_o));
    sbte_emu i_emu (.clk_i(clk_i), .rst_i(rst_i), .record_i(record_o), .rec_cnt_o(rec_cnt));

    task chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t word %h expected %h", $time, got, exp);
        end
    endtask
    task chk_rec(input logic exp_v, input logic [1:0] typ);
        chk_bit(record_o.valid, exp_v);
        if (exp_v) begin
            chk_word({30'h0, record_o.rtype}, {30'h0, typ});
            exp_rec = exp_rec + 32'h1;
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high.
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk_word(q, exp);
    endtask

    // Presents one cycle of events, then lets the registered answer settle.
    task step(input logic [12:0] m, input sbte_branch_t b, input sbte_access_t a, input logic s);
        @(posedge clk_i);
        ch_match_i   <= m;
        branch_i     <= b;
        access_i     <= a;
        soft_trace_i <= s;
        @(posedge clk_i);
        ch_match_i   <= '0;
        branch_i     <= '0;
        access_i     <= '0;
        soft_trace_i <= 1'b0;
        #1;
    endtask
    task ev(input logic [12:0] m, input logic exp_brk);
        step(m, '0, '0, 1'b0);
        chk_bit(break_o, exp_brk);
    endtask

    task t_regs;
        rdc(ADDR_STATUS, RST_ZERO);
        wr(8'h30, 32'hffff_ffff);
        rdc(8'h30, RST_ZERO);
        wr(ADDR_CH_ENABLE, 32'h0000_1ffe);
        rdc(ADDR_CH_ENABLE, 32'h0000_1ffe);
    endtask
    task t_sys;
        wr(ADDR_SEQ_MODE, 32'h10);
        ev(13'h0100, 1'b0);
        ev(13'h0200, 1'b0);
        ev(13'h0100, 1'b1);
        wr(ADDR_SEQ_MODE, 32'h30);
        ev(13'h0200, 1'b0);
        ev(13'h0100, 1'b0);
        ev(13'h0000, 1'b0);
        ev(13'h0200, 1'b1);
    endtask
    task t_cpu;
        wr(ADDR_SEQ_MODE, 32'h1);
        ev(13'h0002, 1'b0);
        ev(13'h0006, 1'b0);
        ev(13'h0002, 1'b1);
        wr(ADDR_SEQ_MODE, 32'h6);
        ev(13'h0400, 1'b0);
        ev(13'h0800, 1'b0);
        ev(13'h0400, 1'b1);
    endtask
    // Ch4 sets the flag for ch2, ch2 arms ch1; ch4 in turn arms only ch10.
    task t_ext;
        wr(ADDR_PRED_BASE + 8'h04, 32'h2);
        wr(ADDR_PRED_BASE + 8'h08, {28'h0, PRED_FLAG});
        wr(ADDR_PRED_BASE + 8'h10, {26'h0, FLAG_SET, 4'h0});
        wr(ADDR_PRED_BASE + 8'h28, 32'h4);
        wr(ADDR_SEQ_MODE, 32'he);
        ev(13'h0004, 1'b0);
        ev(13'h0010, 1'b0);
        chk_bit(cpu_flag_o, 1'b1);
        ev(13'h0002, 1'b0);
        ev(13'h0004, 1'b0);
        ev(13'h0002, 1'b1);
        chk_bit(cpu_flag_o, RST_CPU_FLAG);
    endtask
    task t_branch;
        sbte_branch_t b;
        b = '0;
        b.valid = 1'b1;
        b.src = 32'h0000_1058;
        b.dst = 32'h0000_1068;
        b.kind = SBTE_BR_SUB;
        b.master = 2'h2;
        b.next_pc = 32'h0000_105a;
        wr(ADDR_BR_QUAL, 32'h7f);
        step(13'h0, b, '0, 1'b0);
        chk_rec(1'b1, REC_BRANCH);
        chk_word(record_o.word_a, b.src);
        chk_word(record_o.word_b, b.dst);
        chk_word({27'h0, record_o.kind, record_o.master}, {27'h0, b.kind, b.master});
        b.kind = SBTE_BR_COND;
        b.bf_bt = 1'b1;
        b.zero_disp = 1'b1;
        step(13'h0, b, '0, 1'b0);
        chk_rec(1'b0, REC_BRANCH);
        // A plain reset jump, so that only the reset exclusion can suppress it.
        b.bf_bt = 1'b0;
        b.zero_disp = 1'b0;
        b.kind = SBTE_BR_RESET;
        b.dst = RESET_VECTOR;
        step(13'h0, b, '0, 1'b0);
        chk_rec(1'b0, REC_BRANCH);
        wr(ADDR_BR_QUAL, 32'h7d);
        b.kind = SBTE_BR_COND;
        b.zero_disp = 1'b0;
        step(13'h0, b, '0, 1'b0);
        chk_rec(1'b0, REC_BRANCH);
        b.kind = SBTE_BR_EXC;
        b.completion_exc = 1'b1;
        step(13'h0, b, '0, 1'b0);
        chk_rec(1'b1, REC_BRANCH);
        chk_word(record_o.word_a, b.next_pc);
    endtask
    task t_win;
        sbte_access_t a;
        wr(ADDR_WIN5_LO, 32'h0000_1000);
        wr(ADDR_WIN5_HI, 32'h0000_10ff);
        wr(ADDR_WIN_QUAL, 32'h0001_0011);
        a = '0;
        a.valid = 1'b1;
        a.addr = 32'h0000_10ff;
        a.asid = 8'h06;
        step(13'h0, '0, a, 1'b0);
        chk_rec(1'b1, REC_WINDOW);
        a.addr = 32'h0000_1100;
        step(13'h0, '0, a, 1'b0);
        chk_rec(1'b0, REC_WINDOW);
        a.addr = 32'h0000_1000;
        a.write = 1'b1;
        step(13'h0, '0, a, 1'b0);
        chk_rec(1'b0, REC_WINDOW);
        wr(ADDR_WIN_QUAL, 32'h0001_0501);
        a.write = 1'b0;
        step(13'h0, '0, a, 1'b0);
        chk_rec(1'b0, REC_WINDOW);
        a.asid = 8'h05;
        step(13'h0, '0, a, 1'b0);
        chk_rec(1'b1, REC_WINDOW);
        wr(ADDR_WIN6_LO, 32'h0000_2000);
        wr(ADDR_WIN6_HI, 32'h0000_2000);
        a.addr = 32'h0000_2000;
        step(13'h0, '0, a, 1'b0);
        chk_rec(1'b1, REC_WINDOW);
    endtask
    task t_soft;
        @(posedge clk_i);
        soft_pc_i  <= 32'h0000_0800;
        soft_reg_i <= 32'h0001_0000;
        step(13'h0, '0, '0, 1'b1);
        chk_rec(1'b1, REC_SOFT);
        chk_word(record_o.word_a, 32'h0000_0800);
        chk_word(record_o.word_b, 32'h0001_0000);
    endtask

    task close_out;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_sys;
        t_cpu;
        t_ext;
        t_branch;
        t_win;
        t_soft;
        @(posedge clk_i);
        #1;
        chk_word(rec_cnt, exp_rec);
        close_out;
    end
    // Far beyond the roughly 150 cycles the sequence needs.
    initial begin
        #100000;
        bad_count++;
        close_out;
    end
endmodule
